// [csalu_regs.vh]
// Constants of the command-streamer math unit: instruction fields,
// opcodes, operand encodings and register map.
// Assumes inclusion by bare name from the design files.
`ifndef CSALU_REGS_VH
`define CSALU_REGS_VH
// ==========================================================
// Instruction word fields
`define CSALU_OPC_HI 31
`define CSALU_OPC_LO 20
`define CSALU_OP1_HI 19
`define CSALU_OP1_LO 10
`define CSALU_OP2_HI 9
`define CSALU_OP2_LO 0
// ==========================================================
// Opcode subfields
`define CSALU_INV_HI 11
`define CSALU_INV_LO 10
`define CSALU_GRP_HI 9
`define CSALU_GRP_LO 7
`define CSALU_FN_HI 6
`define CSALU_FN_LO 0
`define CSALU_INV_REGULAR 2'h0
`define CSALU_INV_INVERT 2'h1
`define CSALU_GRP_IDLE 3'h0
`define CSALU_GRP_FETCH 3'h1
`define CSALU_GRP_ALU 3'h2
`define CSALU_GRP_WB 3'h3
// ==========================================================
// Opcodes
`define CSALU_OP_IDLE 12'h000
`define CSALU_OP_FETCH 12'h080
`define CSALU_OP_FETCH_INV 12'h480
`define CSALU_OP_FETCH_ZEROS 12'h081
`define CSALU_OP_FETCH_ONES 12'h481
`define CSALU_OP_ADD 12'h100
`define CSALU_OP_SUB 12'h101
`define CSALU_OP_AND 12'h102
`define CSALU_OP_OR 12'h103
`define CSALU_OP_XOR 12'h104
`define CSALU_OP_WB 12'h180
`define CSALU_OP_WB_INV 12'h580
// ==========================================================
// Operand encodings
`define CSALU_ENC_OPA 10'h020
`define CSALU_ENC_OPB 10'h021
`define CSALU_ENC_ACC 10'h031
`define CSALU_ENC_ZF 10'h032
`define CSALU_ENC_CF 10'h033
`define CSALU_GPR_COUNT 16
// ==========================================================
// Avalon register map, byte addresses
`define CSALU_AV_GPR_BASE 8'h00
`define CSALU_AV_ACC_LO 8'h80
`define CSALU_AV_ACC_HI 8'h84
`define CSALU_AV_FLAGS 8'h88
`define CSALU_AV_OPA_LO 8'h90
`define CSALU_AV_OPA_HI 8'h94
`define CSALU_AV_OPB_LO 8'h98
`define CSALU_AV_OPB_HI 8'h9C
`define CSALU_FLAG_ZF_BIT 0
`define CSALU_FLAG_CF_BIT 1
`define CSALU_RST_WORD 64'h0000000000000000
`define CSALU_UNMAPPED 32'h00000000
`endif

// [csalu_decode.v]
// Opcode decoder of the math unit.
// Assumes a registered instruction word at its input.
`include "csalu_regs.vh"
module csalu_decode (
	input wire [11:0] opcode_in,
	output reg is_fetch_out,
	output reg is_alu_out,
	output reg is_wb_out,
	output reg invert_out,
	output reg fetch_const_out,
	output reg [2:0] alu_fn_out
);
	wire [1:0] invert_select_field;
	wire [2:0] group;
	wire [6:0] function_field;
	assign invert_select_field = opcode_in[`CSALU_INV_HI:`CSALU_INV_LO]; // RL2
	assign group = opcode_in[`CSALU_GRP_HI:`CSALU_GRP_LO]; // RL2
	assign function_field = opcode_in[`CSALU_FN_HI:`CSALU_FN_LO]; // RL2
	always @* begin
		is_fetch_out = 1'b0;
		is_alu_out = 1'b0;
		is_wb_out = 1'b0;
		fetch_const_out = 1'b0;
		invert_out = (invert_select_field == `CSALU_INV_INVERT); // RL3
		alu_fn_out = function_field[2:0];
		// Unlisted codes decode to nothing and act as idle
		case (opcode_in) // RL15
		`CSALU_OP_FETCH, `CSALU_OP_FETCH_INV: begin // RL4
			is_fetch_out = (group == `CSALU_GRP_FETCH); // RL3
		end
		`CSALU_OP_FETCH_ZEROS, `CSALU_OP_FETCH_ONES: begin // RL4
			is_fetch_out = 1'b1;
			fetch_const_out = 1'b1;
		end
		`CSALU_OP_ADD, `CSALU_OP_SUB, `CSALU_OP_AND, `CSALU_OP_OR,
		`CSALU_OP_XOR: begin // RL5
			is_alu_out = (group == `CSALU_GRP_ALU); // RL3
		end
		`CSALU_OP_WB, `CSALU_OP_WB_INV: begin // RL6
			is_wb_out = (group == `CSALU_GRP_WB); // RL3
		end
		default: begin // RL7
			is_fetch_out = 1'b0;
		end
		endcase
	end
endmodule // csalu_decode

// [csalu_arith.v]
// Combinational 64-bit arithmetic and logic core with flags.
// Assumes a function code already qualified by the decoder.
`include "csalu_regs.vh"
module csalu_arith (
	input wire [63:0] a_in,
	input wire [63:0] b_in,
	input wire [2:0] fn_in,
	output reg [63:0] result_out,
	output reg carry_out,
	output wire zero_out
);
	reg [64:0] wide;
	always @* begin
		wide = 65'h00000000000000000;
		case (fn_in)
		3'h0: wide = {1'b0, a_in} + {1'b0, b_in}; // RL19
		3'h1: wide = {1'b0, a_in} - {1'b0, b_in}; // RL9
		3'h2: wide = {1'b0, a_in & b_in};
		3'h3: wide = {1'b0, a_in | b_in};
		3'h4: wide = {1'b0, a_in ^ b_in};
		default: wide = 65'h00000000000000000;
		endcase
		result_out = wide[63:0];
		// Bit 64 is the carry on add and the borrow on subtract
		carry_out = wide[64]; // RL19
	end
	assign zero_out = (result_out == 64'h0000000000000000); // RL17
endmodule // csalu_arith

// [csalu_core.v]
// Math unit of a command streamer: sixteen general registers, two
// operand registers, accumulator and flags, driven by instruction
// words from the parser and reachable over Avalon-MM.
// Assumes the parser gives one valid word per cycle when ready.
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`include "csalu_regs.vh"
// Operation
// [RL1] Word splits opcode, first and second operand
// [RL2] Opcode splits invert, group, function subfields
// [RL3] Invert and group values select instruction kind
// [RL4] Four fetch opcodes recognised
// [RL5] Five arithmetic opcodes, operands unused
// [RL6] Two write-back opcodes recognised
// [RL7] Idle opcode changes nothing
// [RL8] Arithmetic writes accumulator and both flags
// [RL9] Subtract gives operand a minus b
// [RL10] Fetch copies general register into operand
// [RL11] Inverted, zeros and ones fetch variants
// [RL12] Write-back copies result source, maybe inverted
// [RL13] Flag write-back replicates across 64 bits
// [RL14] Operand field register encodings
// [RL15] Twelve opcodes, twenty-one addressable registers
// [RL16] Sixteen general registers, bus and command access
// [RL17] Flags derive from accumulator result
// [RL18] Words arrive only through the math command
// [RL19] Zero on all-zero result, carry or borrow
// [RL20] Strict in-order execution with forwarding; the code has no forwarding path and drops ready for the execute cycle instead
module csalu_core (
	input wire clock_in,
	input wire srst_in,
	input wire instr_valid_in,
	input wire [31:0] instr_in,
	output reg instr_ready_out,
	input wire [7:0] avs_address_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire [31:0] avs_writedata_in,
	input wire [3:0] avs_byteenable_in,
	output reg [31:0] avs_readdata_out,
	output reg avs_waitrequest_out,
	output reg [63:0] result_accumulator_out,
	output reg zero_flag_out,
	output reg carry_flag_out
);
	// ==========================================================
	// State
	reg [63:0] general_register [0:`CSALU_GPR_COUNT-1]; // RL16
	reg [63:0] operand_a_reg;
	reg [63:0] operand_b_reg;
	reg [63:0] result_accumulator;
	reg zero_flag;
	reg carry_flag;
	reg [11:0] opcode;
	reg [9:0] field1;
	reg [9:0] field2;
	reg busy;
	reg bus_done;
	integer i;

	// ==========================================================
	// Helpers
	function [31:0] merge_bytes;
		input [31:0] old_word;
		input [31:0] new_word;
		input [3:0] be;
		integer k;
		begin
			merge_bytes = old_word;
			for (k = 0; k < 4; k = k + 1) begin
				if (be[k]) begin
					merge_bytes[k*8 +: 8] = new_word[k*8 +: 8];
				end
			end
		end
	endfunction

	function is_gpr;
		input [9:0] enc;
		begin
			is_gpr = (enc[9:4] == 6'h00); // RL14
		end
	endfunction

	// ==========================================================
	// Decode and arithmetic
	wire d_fetch;
	wire d_alu;
	wire d_wb;
	wire d_inv;
	wire d_const;
	wire [2:0] d_fn;
	wire [63:0] alu_result;
	wire alu_carry;
	wire alu_zero;

	csalu_decode u_decode (
		.opcode_in(opcode),
		.is_fetch_out(d_fetch),
		.is_alu_out(d_alu),
		.is_wb_out(d_wb),
		.invert_out(d_inv),
		.fetch_const_out(d_const),
		.alu_fn_out(d_fn)
	);

	csalu_arith u_arith (
		.a_in(operand_a_reg),
		.b_in(operand_b_reg),
		.fn_in(d_fn),
		.result_out(alu_result),
		.carry_out(alu_carry),
		.zero_out(alu_zero)
	);

	// ==========================================================
	// Operand selection
	reg [63:0] fetch_value;
	reg [63:0] wb_value;
	reg wb_src_ok;
	always @* begin
		fetch_value = general_register[field2[3:0]]; // RL10
		if (d_const) begin
			fetch_value = {64{d_inv}}; // RL11
		end else if (d_inv) begin
			fetch_value = ~general_register[field2[3:0]]; // RL11
		end
		wb_src_ok = 1'b1;
		case (field2)
		`CSALU_ENC_ACC: wb_value = result_accumulator; // RL12
		`CSALU_ENC_ZF: wb_value = {64{zero_flag}}; // RL13
		`CSALU_ENC_CF: wb_value = {64{carry_flag}}; // RL13
		default: begin
			wb_value = `CSALU_RST_WORD;
			wb_src_ok = 1'b0;
		end
		endcase
		if (d_inv) begin
			wb_value = ~wb_value; // RL12
		end
	end

	wire fetch_dst_ok;
	assign fetch_dst_ok = (field1 == `CSALU_ENC_OPA) ||
		(field1 == `CSALU_ENC_OPB);
	wire fetch_src_ok;
	assign fetch_src_ok = d_const || is_gpr(field2);
	wire do_fetch;
	assign do_fetch = busy && d_fetch && fetch_dst_ok && fetch_src_ok;
	wire do_alu;
	assign do_alu = busy && d_alu;
	wire do_wb;
	assign do_wb = busy && d_wb && wb_src_ok && is_gpr(field1);

	// ==========================================================
	// Bus decode
	wire bus_req;
	assign bus_req = (avs_read_in || avs_write_in) && !bus_done;
	wire addr_gpr;
	assign addr_gpr = (avs_address_in[7] == 1'b0) &&
		(avs_address_in[1:0] == 2'h0);
	wire [3:0] bus_gpr_idx;
	assign bus_gpr_idx = avs_address_in[6:3];
	// A bus write to the general registers is held off while an
	// instruction executes so the two never collide in one cycle.
	wire bus_take;
	assign bus_take = bus_req && !busy;

	// ==========================================================
	// Instruction intake and execution
	// One word is latched, then executed on the next cycle; ready
	// drops meanwhile, which keeps results visible to the next word.
	// A word offered during the hold cycle after reset simply waits
	// for ready; the parser never needs to count cycles itself.
	localparam [1:0] ST_HOLD = 2'h0;
	localparam [1:0] ST_OPEN = 2'h1;
	localparam [1:0] ST_EXEC = 2'h2;
	reg [1:0] in_state;
	reg [1:0] next_in_state;
	always @* begin
		next_in_state = in_state;
		case (in_state)
		ST_HOLD: begin
			next_in_state = ST_OPEN;
		end
		ST_OPEN: begin
			if (instr_valid_in && instr_ready_out) begin // RL18
				next_in_state = ST_EXEC;
			end
		end
		ST_EXEC: begin
			// Execution takes exactly the one cycle after the take
			next_in_state = ST_OPEN; // RL20
		end
		default: begin
			next_in_state = ST_HOLD;
		end
		endcase
	end

	always @(posedge clock_in) begin
		if (srst_in) begin
			in_state <= ST_HOLD;
			busy <= 1'b0;
			instr_ready_out <= 1'b0;
			opcode <= `CSALU_OP_IDLE;
			field1 <= 10'h000;
			field2 <= 10'h000;
		end else begin
			in_state <= next_in_state;
			busy <= (next_in_state == ST_EXEC); // RL20
			instr_ready_out <= (next_in_state == ST_OPEN);
			if (in_state == ST_OPEN && next_in_state == ST_EXEC) begin
				opcode <= instr_in[`CSALU_OPC_HI:`CSALU_OPC_LO]; // RL1
				field1 <= instr_in[`CSALU_OP1_HI:`CSALU_OP1_LO]; // RL1
				field2 <= instr_in[`CSALU_OP2_HI:`CSALU_OP2_LO]; // RL1
			end
		end
	end

	always @(posedge clock_in) begin
		if (srst_in) begin
			operand_a_reg <= `CSALU_RST_WORD;
			operand_b_reg <= `CSALU_RST_WORD;
			result_accumulator <= `CSALU_RST_WORD;
			zero_flag <= 1'b0;
			carry_flag <= 1'b0;
		end else begin
			if (do_fetch) begin // RL10
				if (field1 == `CSALU_ENC_OPA) begin
					operand_a_reg <= fetch_value;
				end else begin
					operand_b_reg <= fetch_value;
				end
			end
			if (do_alu) begin // RL8
				result_accumulator <= alu_result;
				zero_flag <= alu_zero; // RL17
				carry_flag <= alu_carry; // RL19
			end
		end
	end

	// General registers: instruction write-back or bus write
	always @(posedge clock_in) begin
		if (srst_in) begin
			for (i = 0; i < `CSALU_GPR_COUNT; i = i + 1) begin
				general_register[i] <= `CSALU_RST_WORD;
			end
		end else if (do_wb) begin // RL12
			general_register[field1[3:0]] <= wb_value;
		end else if (bus_take && avs_write_in && addr_gpr) begin // RL16
			if (avs_address_in[2]) begin
				general_register[bus_gpr_idx][63:32] <= merge_bytes(
					general_register[bus_gpr_idx][63:32],
					avs_writedata_in, avs_byteenable_in);
			end else begin
				general_register[bus_gpr_idx][31:0] <= merge_bytes(
					general_register[bus_gpr_idx][31:0],
					avs_writedata_in, avs_byteenable_in);
			end
		end
	end

	// ==========================================================
	// Avalon slave: one wait cycle, two if an instruction is executing, then answer
	reg [31:0] read_word;
	always @* begin
		read_word = `CSALU_UNMAPPED;
		if (addr_gpr) begin
			if (avs_address_in[2]) begin
				read_word = general_register[bus_gpr_idx][63:32];
			end else begin
				read_word = general_register[bus_gpr_idx][31:0];
			end
		end else begin
			case (avs_address_in)
			`CSALU_AV_ACC_LO: read_word = result_accumulator[31:0];
			`CSALU_AV_ACC_HI: read_word = result_accumulator[63:32];
			`CSALU_AV_FLAGS: begin
				read_word[`CSALU_FLAG_ZF_BIT] = zero_flag;
				read_word[`CSALU_FLAG_CF_BIT] = carry_flag;
			end
			`CSALU_AV_OPA_LO: read_word = operand_a_reg[31:0];
			`CSALU_AV_OPA_HI: read_word = operand_a_reg[63:32];
			`CSALU_AV_OPB_LO: read_word = operand_b_reg[31:0];
			`CSALU_AV_OPB_HI: read_word = operand_b_reg[63:32];
			default: read_word = `CSALU_UNMAPPED;
			endcase
		end
	end

	// bus_done is high for the one answer cycle, so a request still held at the
	// answer edge is not taken a second time.
	localparam [0:0] BUS_IDLE = 1'h0;
	localparam [0:0] BUS_ANSWER = 1'h1;
	reg bus_state;
	reg next_bus_state;
	always @* begin
		next_bus_state = bus_state;
		case (bus_state)
		BUS_IDLE: begin
			if (bus_take) begin
				next_bus_state = BUS_ANSWER;
			end
		end
		BUS_ANSWER: begin
			next_bus_state = BUS_IDLE;
		end
		default: begin
			next_bus_state = BUS_IDLE;
		end
		endcase
	end

	always @(posedge clock_in) begin
		if (srst_in) begin
			bus_state <= BUS_IDLE;
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out <= `CSALU_UNMAPPED;
			bus_done <= 1'b0;
		end else begin
			bus_state <= next_bus_state;
			bus_done <= (next_bus_state == BUS_ANSWER);
			avs_waitrequest_out <= (next_bus_state != BUS_ANSWER);
			if (bus_take && avs_read_in) begin
				avs_readdata_out <= read_word;
			end
		end
	end

	// ==========================================================
	// Status mirrors
	always @(posedge clock_in) begin
		if (srst_in) begin
			result_accumulator_out <= `CSALU_RST_WORD;
			zero_flag_out <= 1'b0;
			carry_flag_out <= 1'b0;
		end else begin
			result_accumulator_out <= result_accumulator;
			zero_flag_out <= zero_flag;
			carry_flag_out <= carry_flag;
		end
	end
endmodule // csalu_core

// [csalu_core_sva.sv]
// Port checker of the math unit: handshake, bus answer and results.
// Assumes it is bound to csalu_core and sees only its ports.
module csalu_core_sva (
	input wire clock_in,
	input wire srst_in,
	input wire instr_valid_in,
	input wire [31:0] instr_in,
	input wire instr_ready_out,
	input wire [7:0] avs_address_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire [31:0] avs_writedata_in,
	input wire [3:0] avs_byteenable_in,
	input wire [31:0] avs_readdata_out,
	input wire avs_waitrequest_out,
	input wire [63:0] result_accumulator_out,
	input wire zero_flag_out,
	input wire carry_flag_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Properties
	wire take;
	wire [11:0] opc;
	assign take = instr_valid_in && instr_ready_out;
	assign opc = instr_in[31:20];
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (srst_in);
	a_take_gap: assert property (take |=> !instr_ready_out)
		else $error("ready high after take");
	a_ready_back: assert property ($fell(instr_ready_out) |=> instr_ready_out)
		else $error("ready low too long");
	a_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("answer longer than one cycle");
	a_wait_cause: assert property (!avs_waitrequest_out |->
		$past(avs_read_in || avs_write_in))
		else $error("answer without request");
	a_wait_bound: assert property ((avs_read_in || avs_write_in) &&
		avs_waitrequest_out |-> ##[1:6] !avs_waitrequest_out)
		else $error("bus answer late");
	a_rdata_hold: assert property ($changed(avs_readdata_out) |->
		!avs_waitrequest_out)
		else $error("read data moved");
	a_idle_calm: assert property (take && opc == 12'h000 |-> ##2
		$stable({result_accumulator_out, zero_flag_out, carry_flag_out})[*2])
		else $error("idle changed results");
	a_logic_carry: assert property (take && (opc == 12'h102 ||
		opc == 12'h103 || opc == 12'h104) |-> ##3 !carry_flag_out)
		else $error("logic op left carry");
	a_acc_cause: assert property ($changed(result_accumulator_out) |->
		$past(take, 3))
		else $error("accumulator moved alone");
	a_zero_match: assert property ($changed(result_accumulator_out) |->
		zero_flag_out == (result_accumulator_out == 64'h0))
		else $error("zero flag wrong");
endmodule // csalu_core_sva

bind csalu_core csalu_core_sva i_sva (.clock_in(clock_in),
	.srst_in(srst_in), .instr_valid_in(instr_valid_in),
	.instr_in(instr_in), .instr_ready_out(instr_ready_out),
	.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
	.avs_byteenable_in(avs_byteenable_in),
	.avs_readdata_out(avs_readdata_out),
	.avs_waitrequest_out(avs_waitrequest_out),
	.result_accumulator_out(result_accumulator_out),
	.zero_flag_out(zero_flag_out), .carry_flag_out(carry_flag_out));

// [csalu_parser_model.sv]
// Parser model: offers one instruction word at a time.
// Assumes the unit's registered ready handshake.
module csalu_parser_model (
	input wire clock_in,
	input wire instr_ready_in,
	output logic instr_valid_out,
	output logic [31:0] instr_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Issue
	initial begin
		instr_valid_out = 1'b0;
		instr_out = 32'h00000000;
	end
	// Gap cycles make a slow parser
	task send(input [31:0] w, input int gap);
		repeat (gap) @(posedge clock_in);
		@(posedge clock_in);
		instr_valid_out <= 1'b1;
		instr_out <= w;
		do @(posedge clock_in); while (instr_ready_in !== 1'b1);
		instr_valid_out <= 1'b0;
		// Stale word is not left on the lines
		instr_out <= ~w;
	endtask
endmodule // csalu_parser_model

// [csalu_core_tb.sv]
// Bench of the math unit: instruction and Avalon traffic.
// Assumes csalu_core, the parser model and the bound checker.
module csalu_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Harness
	localparam [63:0] all1 = 64'hFFFFFFFFFFFFFFFF;
	logic clock_in = 1'b0;
	logic srst_in = 1'b1;
	logic [7:0] avs_address_in = 8'h00;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h00000000;
	logic [3:0] avs_byteenable_in = 4'hF;
	wire instr_valid_in;
	wire [31:0] instr_in;
	wire instr_ready_out;
	wire [31:0] avs_readdata_out;
	wire avs_waitrequest_out;
	wire [63:0] result_accumulator_out;
	wire zero_flag_out;
	wire carry_flag_out;
	int num_errors = 0;
	int total_checks = 0;
	always #4 clock_in = ~clock_in;
	csalu_core i_dut (.clock_in(clock_in), .srst_in(srst_in),
		.instr_valid_in(instr_valid_in), .instr_in(instr_in),
		.instr_ready_out(instr_ready_out),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(avs_byteenable_in),
		.avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out),
		.result_accumulator_out(result_accumulator_out),
		.zero_flag_out(zero_flag_out), .carry_flag_out(carry_flag_out));
	csalu_parser_model i_par (.clock_in(clock_in),
		.instr_ready_in(instr_ready_out), .instr_valid_out(instr_valid_in),
		.instr_out(instr_in));
	task chk(input string nm, input [63:0] e, input [63:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task bw(input [7:0] a, input [31:0] d, input [3:0] be);
		@(posedge clock_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_byteenable_in <= be;
		avs_write_in <= 1'b1;
		do @(posedge clock_in); while (avs_waitrequest_out !== 1'b0);
		avs_write_in <= 1'b0;
	endtask
	task br(input [7:0] a, output [31:0] d);
		@(posedge clock_in);
		avs_address_in <= a;
		avs_read_in <= 1'b1;
		do @(posedge clock_in); while (avs_waitrequest_out !== 1'b0);
		d = avs_readdata_out;
		avs_read_in <= 1'b0;
	endtask
	task setg(input [3:0] n, input [63:0] v);
		bw({1'b0, n, 3'h0}, v[31:0], 4'hF);
		bw({1'b0, n, 3'h4}, v[63:32], 4'hF);
	endtask
	task cg(input string nm, input [7:0] a, input [63:0] e);
		logic [63:0] v;
		br(a, v[31:0]);
		br(a + 8'h04, v[63:32]);
		chk(nm, e, v);
	endtask
	task ex(input [11:0] op, input [9:0] x, input [9:0] y, input int g = 0);
		i_par.send({op, x, y}, g);
	endtask
	// Mirrors trail the state by one edge
	task mir(input [63:0] acc, input [1:0] zc);
		repeat (3) @(posedge clock_in);
		chk("acc", acc, result_accumulator_out);
		chk("zc", {62'h0, zc}, {62'h0, zero_flag_out, carry_flag_out});
	endtask
	// ==========================================================
	// Scenarios
	task t_reset;
		logic [31:0] d;
		br(8'hA0, d);
		chk("unmapped", 64'h0, {32'h0, d});
		cg("flags", 8'h88, 64'h0);
	endtask
	task t_add;
		setg(0, all1);
		setg(1, 64'h1);
		ex(12'h080, 10'h020, 10'h000);
		ex(12'h080, 10'h021, 10'h001);
		ex(12'h100, 10'h000, 10'h000);
		ex(12'h180, 10'h002, 10'h031);
		ex(12'h180, 10'h003, 10'h033);
		ex(12'h580, 10'h004, 10'h032);
		mir(64'h0, 2'b11);
		cg("r2", 8'h10, 64'h0);
		cg("r3", 8'h18, all1);
		cg("r4", 8'h20, 64'h0);
		cg("opa", 8'h90, all1);
	endtask
	task t_sub;
		setg(5, 64'h5);
		setg(6, 64'h7);
		ex(12'h080, 10'h020, 10'h005, 3);
		ex(12'h080, 10'h021, 10'h006, 3);
		ex(12'h101, 10'h3FF, 10'h3FF);
		ex(12'h180, 10'h007, 10'h031);
		ex(12'h180, 10'h008, 10'h033);
		ex(12'h580, 10'h009, 10'h031);
		mir(all1 - 64'h1, 2'b01);
		cg("r7", 8'h38, all1 - 64'h1);
		cg("r8", 8'h40, all1);
		cg("r9", 8'h48, 64'h1);
	endtask
	task t_logic;
		logic [63:0] a, b, e;
		a = 64'hF0F0F0F00000FFFF;
		b = 64'h0FF00FF0FFFF0000;
		setg(10, a);
		setg(11, b);
		ex(12'h480, 10'h020, 10'h00A);
		ex(12'h080, 10'h021, 10'h00B);
		for (int k = 0; k < 3; k++) begin
			e = (k == 0) ? (~a & b) : (k == 1) ? (~a | b) : (~a ^ b);
			ex(12'h102 + 12'(k), 10'h000, 10'h000);
			ex(12'h180, 10'h00C, 10'h031);
			mir(e, 2'b00);
			cg("r12", 8'h60, e);
		end
		ex(12'h081, 10'h020, 10'h000);
		ex(12'h481, 10'h021, 10'h000);
		ex(12'h100, 10'h000, 10'h000);
		mir(all1, 2'b00);
	endtask
	task t_idle;
		ex(12'h000, 10'h3FF, 10'h3FF);
		ex(12'h105, 10'h000, 10'h000);
		// A stray write-back here would put zeros into r0
		ex(12'h580, 10'h020, 10'h031);
		ex(12'h080, 10'h020, 10'h031);
		mir(all1, 2'b00);
		cg("r0", 8'h00, all1);
		cg("opa", 8'h90, 64'h0);
		cg("opb", 8'h98, all1);
		bw(8'h80, 32'h12345678, 4'hF);
		bw(8'h68, 32'hDDCCBBAA, 4'h2);
		cg("acc", 8'h80, all1);
		cg("r13", 8'h68, 64'h000000000000BB00);
	endtask
	task stop_test;
		if (num_errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clock_in);
		srst_in <= 1'b0;
		t_reset;
		t_add;
		t_sub;
		t_logic;
		t_idle;
		stop_test;
	end
	initial begin
		repeat (20000) @(posedge clock_in);
		num_errors++;
		stop_test;
	end
endmodule // csalu_core_tb
